// [hpi_pkg.sv]
// hpi_pkg: constants and types shared by the hub port status indicator block
// assumes: one system clock, synchronous active-low reset
package hpi_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_DN_PORTS = 6;
  localparam int NUM_UP_PORTS = 2;

  // ==========================================================================
  // clock
  localparam int CLK_SYS_HZ = 10_000_000;

  // ==========================================================================
  // positions of pin inputs inside the synchroniser vector
  localparam int SYNC_WIDTH        = 4;
  localparam int PIN_MODE_STRAP    = 0;
  localparam int PIN_CLKSRC_STRAP  = 1;
  localparam int PIN_MGMT_CLOCK    = 2;
  localparam int PIN_MGMT_DATA     = 3;

  // ==========================================================================
  // management pin roles, as decoded from the mode strap
  localparam logic ROLE_SMB_SLAVE  = 1'h0;
  localparam logic ROLE_I2C_BRIDGE = 1'h1;

  // clock source, as decoded from the clock source strap
  localparam logic SRC_CRYSTAL     = 1'h0;
  localparam logic SRC_OSCILLATOR  = 1'h1;

  // ==========================================================================
  // sequencing states
  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN     = 2'b10
  } hpi_state_t;

  // ==========================================================================
  // complete state of the main module
  typedef struct packed {
    hpi_state_t                state;
    logic                      mgmtRole;
    logic                      clkSource;
    logic [NUM_DN_PORTS-1:0]   dnSpeedOut;
    logic [NUM_DN_PORTS-1:0]   dnSpeedOe;
    logic [NUM_DN_PORTS-1:0]   chgOut;
    logic [NUM_DN_PORTS-1:0]   chgOe;
    logic [NUM_UP_PORTS-1:0]   upSpeedOut;
    logic [NUM_UP_PORTS-1:0]   upSpeedOe;
    logic                      suspOut;
    logic                      suspOe;
    logic                      inReset;
    logic                      mgmtClockOe;
    logic                      mgmtDataOe;
  } hpi_regs_t;

  // ==========================================================================
  // reset values
  localparam logic ROLE_RST      = ROLE_SMB_SLAVE;
  localparam logic CLKSRC_RST    = SRC_CRYSTAL;
  localparam logic IND_OUT_RST   = 1'h0;
  localparam logic IND_OE_RST    = 1'h0;
  localparam logic IN_RESET_RST  = 1'h1;

  localparam hpi_regs_t HPI_REGS_RST = '{
    state:       ST_RESET,
    mgmtRole:    ROLE_RST,
    clkSource:   CLKSRC_RST,
    dnSpeedOut:  {NUM_DN_PORTS{IND_OUT_RST}},
    dnSpeedOe:   {NUM_DN_PORTS{IND_OE_RST}},
    chgOut:      {NUM_DN_PORTS{IND_OUT_RST}},
    chgOe:       {NUM_DN_PORTS{IND_OE_RST}},
    upSpeedOut:  {NUM_UP_PORTS{IND_OUT_RST}},
    upSpeedOe:   {NUM_UP_PORTS{IND_OE_RST}},
    suspOut:     IND_OUT_RST,
    suspOe:      IND_OE_RST,
    inReset:     IN_RESET_RST,
    mgmtClockOe: IND_OE_RST,
    mgmtDataOe:  IND_OE_RST
  };

endpackage

// [hpi_sync.sv]
// hpi_sync: three-stage synchroniser bank with agreement filter
// assumes: inputs are asynchronous pins; no reset, the chain settles itself
`timescale 1ns/1ns
`default_nettype none

module hpi_sync #(
  parameter int WIDTH = 4
) (
  // clock
  input  wire logic             clk_sys,
  // asynchronous pins
  input  wire logic [WIDTH-1:0] pinIn,
  // filtered, synchronised levels
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } hpi_sync_regs_t;

  hpi_sync_regs_t r_ff;
  hpi_sync_regs_t nxt_r;

  // ==========================================================================
  // next state: a change counts once stages two and three agree
  always_comb begin
    nxt_r    = r_ff;
    nxt_r.s1 = pinIn;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r_ff.s2[i] == r_ff.s3[i]) begin
        nxt_r.level[i] = r_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    r_ff <= nxt_r;
  end

  assign syncOut = r_ff.level;

endmodule

`default_nettype wire

// [hpi_top.sv]
// hpi_top: sideband status indicators, reset sequencing and management pin
// role selection of the hub
// assumes: port status inputs come from hub logic on clk_sys; straps and the
// management lines are asynchronous pins; pin tristate is resolved outside;
// straps stand still for four edges before reset releases, since the
// synchronisers carry no reset and need that long to settle
//
// Summary of operation
// - port speed pin floats unconnected, low for 2.0/1.1, high for Gen 1.
// - charge pin floats if disabled, low after handshake, high before it.
// - host speed pin floats unconnected, low for Gen 1, high for 2.0/1.1.
// - hub stays in reset mode while the active-low chip reset is low.
// - a dedicated pin shows the USB 2.0 suspend state for sideband wakeup.
// - management lines act as SMBus slave or I2C bridge by configuration.
// - reference from crystal or oscillator; oscillator idles crystal out.
// - straps, mode strap included, latch at each reset release.
`timescale 1ns/1ns
`default_nettype none

module hpi_top
  import hpi_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,

  // downstream port status from hub logic
  input  wire logic [NUM_DN_PORTS-1:0] dnConnected,
  input  wire logic [NUM_DN_PORTS-1:0] dnGen1Link,
  input  wire logic [NUM_DN_PORTS-1:0] chargeEnabled,
  input  wire logic [NUM_DN_PORTS-1:0] chargeHandshakeDone,

  // host-facing port status from hub logic
  input  wire logic [NUM_UP_PORTS-1:0] upConnected,
  input  wire logic [NUM_UP_PORTS-1:0] upGen1Link,

  // suspend state from hub logic
  input  wire logic                    usb2Suspended,

  // configuration strap pins
  input  wire logic                    modeStrapPin,
  input  wire logic                    clkSrcStrapPin,

  // downstream speed pins
  output logic      [NUM_DN_PORTS-1:0] downstreamSpeedFlagOut,
  output logic      [NUM_DN_PORTS-1:0] downstreamSpeedFlagOe,

  // charge handshake pins
  output logic      [NUM_DN_PORTS-1:0] chargeHandshakeFlagOut,
  output logic      [NUM_DN_PORTS-1:0] chargeHandshakeFlagOe,

  // host port speed pins
  output logic      [NUM_UP_PORTS-1:0] hostSpeedFlagOut,
  output logic      [NUM_UP_PORTS-1:0] hostSpeedFlagOe,

  // suspend pin
  output logic                         suspendWakeFlagOut,
  output logic                         suspendWakeFlagOe,

  // hub state
  output logic                         hubInReset,
  output logic                         strapsValid,

  // reference clock source
  output logic                         refClockInputSelect,
  output logic                         crystalOutEnable,

  // management clock line
  input  wire logic                    mgmtClockLineIn,
  output logic                         mgmtClockLineOut,
  output logic                         mgmtClockLineOe,

  // management data line
  input  wire logic                    mgmtDataLineIn,
  output logic                         mgmtDataLineOut,
  output logic                         mgmtDataLineOe,

  // SMBus slave engine
  input  wire logic                    slaveClockDriveLow,
  input  wire logic                    slaveDataDriveLow,
  output logic                         slaveSelected,

  // I2C bridge master engine
  input  wire logic                    bridgeClockDriveLow,
  input  wire logic                    bridgeDataDriveLow,
  output logic                         bridgeSelected,

  // synchronised line levels for both engines
  output logic                         mgmtClockSync,
  output logic                         mgmtDataSync
);

  hpi_regs_t             r_ff;
  hpi_regs_t             nxt_r;
  logic [SYNC_WIDTH-1:0] pinRaw;
  logic [SYNC_WIDTH-1:0] pinSync;

  // ==========================================================================
  // decodes used by the next-state logic and the outputs
  function automatic logic is_run(input hpi_state_t st);
    is_run = (st == ST_RUN);
  endfunction

  // only the engine of the strapped role may pull a line low
  function automatic logic pick_pull(input logic role,
                                     input logic bridgePull,
                                     input logic slavePull);
    pick_pull = (role == ROLE_I2C_BRIDGE) ? bridgePull : slavePull;
  endfunction

  // ==========================================================================
  // pin synchronisers
  // strap and line pins are asynchronous; each passes three synchroniser flops and the filter flop
  always_comb begin
    pinRaw                   = '0;
    pinRaw[PIN_MODE_STRAP]   = modeStrapPin;
    pinRaw[PIN_CLKSRC_STRAP] = clkSrcStrapPin;
    pinRaw[PIN_MGMT_CLOCK]   = mgmtClockLineIn;
    pinRaw[PIN_MGMT_DATA]    = mgmtDataLineIn;
  end

  hpi_sync #(
    .WIDTH   (SYNC_WIDTH)
  ) u_sync (
    .clk_sys (clk_sys),
    .pinIn   (pinRaw),
    .syncOut (pinSync)
  );

  // ==========================================================================
  // next state
  always_comb begin
    nxt_r         = r_ff;
    nxt_r.inReset = 1'h0;

    unique case (r_ff.state)
      ST_RESET: begin
        // first edge after release moves to capture; the second latches the straps
        nxt_r.state = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        // a strap change after this point waits for the next reset
        nxt_r.mgmtRole  = pinSync[PIN_MODE_STRAP];
        nxt_r.clkSource = pinSync[PIN_CLKSRC_STRAP];
        nxt_r.state     = ST_RUN;
      end
      ST_RUN: begin
        nxt_r.state = ST_RUN;
      end
      default: begin
        nxt_r.state = ST_RESET;
      end
    endcase

    // indicators follow port state only once straps are taken
    if (is_run(r_ff.state)) begin
      nxt_r.dnSpeedOe   = dnConnected;
      nxt_r.dnSpeedOut  = dnGen1Link;
      nxt_r.chgOe       = chargeEnabled;
      nxt_r.chgOut      = ~chargeHandshakeDone;
      nxt_r.upSpeedOe   = upConnected;
      nxt_r.upSpeedOut  = ~upGen1Link;
      nxt_r.suspOe      = 1'h1;
      nxt_r.suspOut     = usb2Suspended;
      nxt_r.mgmtClockOe = pick_pull(r_ff.mgmtRole, bridgeClockDriveLow,
                                    slaveClockDriveLow);
      nxt_r.mgmtDataOe  = pick_pull(r_ff.mgmtRole, bridgeDataDriveLow,
                                    slaveDataDriveLow);
    end else begin
      // outside run every pin floats; stored levels are kept
      nxt_r.dnSpeedOe   = {NUM_DN_PORTS{IND_OE_RST}};
      nxt_r.chgOe       = {NUM_DN_PORTS{IND_OE_RST}};
      nxt_r.upSpeedOe   = {NUM_UP_PORTS{IND_OE_RST}};
      nxt_r.suspOe      = IND_OE_RST;
      nxt_r.mgmtClockOe = IND_OE_RST;
      nxt_r.mgmtDataOe  = IND_OE_RST;
    end
  end

  // ==========================================================================
  // state register; reset floats every indicator
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_ff <= HPI_REGS_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================================================
  // outputs
  assign downstreamSpeedFlagOut = r_ff.dnSpeedOut;
  assign downstreamSpeedFlagOe  = r_ff.dnSpeedOe;
  assign chargeHandshakeFlagOut = r_ff.chgOut;
  assign chargeHandshakeFlagOe  = r_ff.chgOe;
  assign hostSpeedFlagOut       = r_ff.upSpeedOut;
  assign hostSpeedFlagOe        = r_ff.upSpeedOe;
  assign suspendWakeFlagOut     = r_ff.suspOut;
  assign suspendWakeFlagOe      = r_ff.suspOe;

  // hub logic leaves its reset mode one edge after release
  assign hubInReset  = r_ff.inReset;
  assign strapsValid = is_run(r_ff.state);

  // oscillator mode idles the crystal amplifier
  assign refClockInputSelect = (r_ff.clkSource == SRC_OSCILLATOR);
  assign crystalOutEnable    = (r_ff.clkSource == SRC_CRYSTAL);

  // open-drain lines only ever pull low
  assign mgmtClockLineOut = 1'h0;
  assign mgmtClockLineOe  = r_ff.mgmtClockOe;
  assign mgmtDataLineOut  = 1'h0;
  assign mgmtDataLineOe   = r_ff.mgmtDataOe;

  // role selects stay low until the straps are taken
  assign slaveSelected  = strapsValid && (r_ff.mgmtRole == ROLE_SMB_SLAVE);
  assign bridgeSelected = strapsValid && (r_ff.mgmtRole == ROLE_I2C_BRIDGE);
  assign mgmtClockSync  = pinSync[PIN_MGMT_CLOCK];
  assign mgmtDataSync   = pinSync[PIN_MGMT_DATA];

endmodule

`default_nettype wire

// [hpi_board.sv]
// hpi_board: board side of the hub indicator and management pins
// assumes: indicator pins carry no pull; management lines are pulled up
`timescale 1ns/1ns
`default_nettype none
module hpi_board
  import hpi_pkg::*;
(
  // indicator drivers of the hub
  input  wire logic [NUM_DN_PORTS-1:0] downstreamSpeedFlagOut,
  input  wire logic [NUM_DN_PORTS-1:0] downstreamSpeedFlagOe,
  input  wire logic [NUM_DN_PORTS-1:0] chargeHandshakeFlagOut,
  input  wire logic [NUM_DN_PORTS-1:0] chargeHandshakeFlagOe,
  input  wire logic [NUM_UP_PORTS-1:0] hostSpeedFlagOut,
  input  wire logic [NUM_UP_PORTS-1:0] hostSpeedFlagOe,
  input  wire logic                    suspendWakeFlagOut,
  input  wire logic                    suspendWakeFlagOe,
  // management line pulls
  input  wire logic                    mgmtClockLineOe,
  input  wire logic                    mgmtDataLineOe,
  input  wire logic                    extClockLow,
  input  wire logic                    extDataLow,
  // resolved pins
  output logic      [NUM_DN_PORTS-1:0] dnPin,
  output logic      [NUM_DN_PORTS-1:0] chgPin,
  output logic      [NUM_UP_PORTS-1:0] hostPin,
  output logic                         suspPin,
  output logic                         mgmtClockLineIn,
  output logic                         mgmtDataLineIn
);
  // an undriven pin floats, as an LED or sideband input would see it
  for (genvar i = 0; i < NUM_DN_PORTS; i++) begin : g_dn
    assign dnPin[i] = downstreamSpeedFlagOe[i] ?
                      downstreamSpeedFlagOut[i] : 1'bz;
    assign chgPin[i] = chargeHandshakeFlagOe[i] ?
                       chargeHandshakeFlagOut[i] : 1'bz;
  end
  for (genvar i = 0; i < NUM_UP_PORTS; i++) begin : g_up
    assign hostPin[i] = hostSpeedFlagOe[i] ? hostSpeedFlagOut[i] : 1'bz;
  end
  assign suspPin = suspendWakeFlagOe ? suspendWakeFlagOut : 1'bz;
  // wired-and with pull-up
  assign mgmtClockLineIn = !(mgmtClockLineOe || extClockLow);
  assign mgmtDataLineIn = !(mgmtDataLineOe || extDataLow);
endmodule
`default_nettype wire

// [hpi_top_assertions.sv]
// hpi_top_assertions: port-level checks of hpi_top
// assumes: bound to hpi_top; one clock, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module hpi_top_chk
  import hpi_pkg::*;
(
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  // status inputs
  input wire logic [NUM_DN_PORTS-1:0] dnConnected,
  input wire logic [NUM_DN_PORTS-1:0] dnGen1Link,
  input wire logic [NUM_DN_PORTS-1:0] chargeEnabled,
  input wire logic [NUM_DN_PORTS-1:0] chargeHandshakeDone,
  input wire logic [NUM_UP_PORTS-1:0] upConnected,
  input wire logic [NUM_UP_PORTS-1:0] upGen1Link,
  input wire logic                    usb2Suspended,
  input wire logic                    slaveDataDriveLow,
  input wire logic                    bridgeDataDriveLow,
  // outputs
  input wire logic [NUM_DN_PORTS-1:0] downstreamSpeedFlagOut,
  input wire logic [NUM_DN_PORTS-1:0] downstreamSpeedFlagOe,
  input wire logic [NUM_DN_PORTS-1:0] chargeHandshakeFlagOut,
  input wire logic [NUM_DN_PORTS-1:0] chargeHandshakeFlagOe,
  input wire logic [NUM_UP_PORTS-1:0] hostSpeedFlagOut,
  input wire logic [NUM_UP_PORTS-1:0] hostSpeedFlagOe,
  input wire logic                    suspendWakeFlagOut,
  input wire logic                    suspendWakeFlagOe,
  input wire logic                    hubInReset,
  input wire logic                    strapsValid,
  input wire logic                    refClockInputSelect,
  input wire logic                    crystalOutEnable,
  input wire logic                    mgmtDataLineOe,
  input wire logic                    slaveSelected,
  input wire logic                    bridgeSelected
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // indicators
  dn_speed_a: assert property (
    strapsValid |=> downstreamSpeedFlagOe == $past(dnConnected) &&
    ((downstreamSpeedFlagOut ^ $past(dnGen1Link)) & $past(dnConnected)) == 0)
    else $error("downstream speed pin wrong");
  chg_flag_a: assert property (
    strapsValid |=> chargeHandshakeFlagOe == $past(chargeEnabled) &&
    ((chargeHandshakeFlagOut ^ ~$past(chargeHandshakeDone))
     & $past(chargeEnabled)) == 0)
    else $error("charge pin wrong");
  host_speed_a: assert property (
    strapsValid |=> hostSpeedFlagOe == $past(upConnected) &&
    ((hostSpeedFlagOut ^ ~$past(upGen1Link)) & $past(upConnected)) == 0)
    else $error("host speed pin wrong");
  susp_flag_a: assert property (
    strapsValid |=> suspendWakeFlagOe && suspendWakeFlagOut ==
    $past(usb2Suspended)) else $error("suspend pin wrong");
  // ==========================================================================
  // reset and straps
  reset_float_a: assert property (disable iff (1'b0)
    !rst_n |=> hubInReset && !strapsValid && !suspendWakeFlagOe &&
    downstreamSpeedFlagOe == 0 && chargeHandshakeFlagOe == 0 &&
    hostSpeedFlagOe == 0) else $error("outputs driven in reset");
  role_sel_a: assert property (
    (slaveSelected | bridgeSelected) == strapsValid &&
    !(slaveSelected && bridgeSelected)) else $error("role select wrong");
  mgmt_pull_a: assert property (
    strapsValid |=> mgmtDataLineOe == ($past(bridgeSelected) ?
    $past(bridgeDataDriveLow) : $past(slaveDataDriveLow)))
    else $error("data line pull wrong");
  clk_src_a: assert property (
    strapsValid |-> crystalOutEnable == !refClockInputSelect)
    else $error("crystal amp and source disagree");
  strap_hold_a: assert property (
    strapsValid && $past(strapsValid) |-> $stable(refClockInputSelect) &&
    $stable(bridgeSelected)) else $error("strap changed in run");
  cover property (strapsValid && bridgeSelected);
  cover property (strapsValid && refClockInputSelect);
  cover property ($rose(strapsValid));
endmodule
bind hpi_top hpi_top_chk u_chk (.*);
`default_nettype wire

// [hpi_top_bench.sv]
// hpi_top_bench: corner and random stimulus of hpi_top, pin-level checks
// assumes: hpi_board resolves the pins; 10 MHz clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module hpi_top_bench
  import hpi_pkg::*;
;
  logic clk_sys, rst_n, usb2Suspended, modeStrapPin, clkSrcStrapPin;
  logic slaveClockDriveLow, slaveDataDriveLow, slaveSelected;
  logic bridgeClockDriveLow, bridgeDataDriveLow, bridgeSelected;
  logic suspendWakeFlagOut, suspendWakeFlagOe, suspPin, hubInReset;
  logic strapsValid, refClockInputSelect, crystalOutEnable;
  logic mgmtClockLineIn, mgmtClockLineOut, mgmtClockLineOe, mgmtClockSync;
  logic mgmtDataLineIn, mgmtDataLineOut, mgmtDataLineOe, mgmtDataSync;
  logic extClockLow, extDataLow;
  logic [5:0] dnConnected, dnGen1Link, chargeEnabled, chargeHandshakeDone;
  logic [5:0] downstreamSpeedFlagOut, downstreamSpeedFlagOe, dnPin;
  logic [5:0] chargeHandshakeFlagOut, chargeHandshakeFlagOe, chgPin;
  logic [1:0] upConnected, upGen1Link, hostSpeedFlagOut, hostSpeedFlagOe;
  logic [1:0] hostPin, mode;
  int         fails, checked, cyc;

  hpi_top   dut_u (.*);
  hpi_board brd_u (.*);

  // ==========================================================================
  // helpers
  function automatic logic [5:0] tri6(input logic [5:0] oe, v);
    for (int i = 0; i < 6; i++) tri6[i] = oe[i] ? v[i] : 1'bz;
  endfunction
  task tick;
    @(posedge clk_sys);
    #5;
  endtask
  task set(input logic [32:0] v);
    {dnConnected, dnGen1Link, chargeEnabled, chargeHandshakeDone,
     upConnected, upGen1Link, usb2Suspended, slaveClockDriveLow,
     slaveDataDriveLow, bridgeClockDriveLow, bridgeDataDriveLow} = v;
  endtask
  task automatic drive(input logic [32:0] v);
    logic [5:0] eh;
    logic       ec;
    logic       ed;
    set(v);
    tick;
    eh = tri6({4'h0, upConnected}, ~{4'h0, upGen1Link});
    `CHK("dnPin", tri6(dnConnected, dnGen1Link), dnPin)
    `CHK("chgPin", tri6(chargeEnabled, ~chargeHandshakeDone), chgPin)
    `CHK("hostPin", eh[1:0], hostPin)
    `CHK("suspPin", usb2Suspended, suspPin)
    ec = mode[1] ? bridgeClockDriveLow : slaveClockDriveLow;
    ed = mode[1] ? bridgeDataDriveLow : slaveDataDriveLow;
    `CHK("clkOe", ec, mgmtClockLineOe)
    `CHK("dataOe", ed, mgmtDataLineOe)
  endtask
  task stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      stop_test;
    end
  end

  // ==========================================================================
  // one pass per strap setting, each after the first entering reset from run
  initial begin
    void'($urandom(3242));
    rst_n = 1'b0;
    extClockLow = 1'b0;
    extDataLow = 1'b0;
    mode = 2'h0;
    {modeStrapPin, clkSrcStrapPin} = mode;
    set(33'h0);
    for (int k = 0; k < 4; k++) begin
      mode = k[1:0];
      {modeStrapPin, clkSrcStrapPin} = mode;
      rst_n = 1'b0;
      repeat (20) tick;
      `CHK("inReset", 1'b1, hubInReset)
      `CHK("dnPin", {6{1'bz}}, dnPin)
      `CHK("suspPin", 1'bz, suspPin)
      `CHK("chgPin", {6{1'bz}}, chgPin)
      `CHK("hostPin", {2{1'bz}}, hostPin)
      rst_n = 1'b1;
      repeat (2) tick;
      `CHK("valid", 1'b1, strapsValid)
      `CHK("bridge", mode[1], bridgeSelected)
      `CHK("slave", ~mode[1], slaveSelected)
      `CHK("outReset", 1'b0, hubInReset)
      `CHK("osc", mode[0], refClockInputSelect)
      `CHK("xtal", ~mode[0], crystalOutEnable)
      {modeStrapPin, clkSrcStrapPin} = ~mode;
      drive('1);
      drive('0);
      repeat (60) drive(33'({$urandom, $urandom}));
      set(33'h0);
      extDataLow = 1'b1;
      extClockLow = 1'b1;
      repeat (6) tick;
      `CHK("dataSync", 1'b0, mgmtDataSync)
      `CHK("clkSync", 1'b0, mgmtClockSync)
      `CHK("oscHeld", mode[0], refClockInputSelect)
      `CHK("bridgeHeld", mode[1], bridgeSelected)
      `CHK("dataOut", 1'b0, mgmtDataLineOut)
      `CHK("clkOut", 1'b0, mgmtClockLineOut)
      extDataLow = 1'b0;
      extClockLow = 1'b0;
      repeat (6) tick;
      `CHK("dataIdle", 1'b1, mgmtDataSync)
      `CHK("clkIdle", 1'b1, mgmtClockSync)
      $display("test mode %0d done", k);
    end
    stop_test;
  end
endmodule
`default_nettype wire
